// ### logic/asc_adc_ctrl.sv
// Converter control: register port, low-power modes, break gating, interrupts.
// Assumes stop and break levels come from logic on mclk_i; the trigger is a pin.
//
// Operation
// - Interrupt request rises with the done flag when interrupt enable is set
// - Done flag sets at every conversion end not blocked by a 10-bit high result read awaiting its low read, regardless of interrupt enable
// - Wait mode does not disturb conversions or their completion interrupt
// - Single mode drops converter into low-power idle after each unblocked conversion and restarts a blocked one
// - Stop entry without async clock aborts conversion and idles converter
// - After such a stop, idle until software writes the control register
// - Aborts leave result registers holding the last completed result
// - With async clock enabled, stop mode changes nothing
// - External mode in stop with async clock enabled waits for trigger, then converts once
// - No trigger source on this device; trigger input held inactive
// - With break clearing disabled, break accesses leave flags unchanged
// - Two-step clear started before break completes only after break
// - Result is a rounded 8 or 10 bit code
// - Control write or low result read clears done flag and request
// - Channel field all ones switches converter off
// - Outside external mode, continuous mode repeats conversions and single mode runs one per control write
`timescale 1ns/10ps
`default_nettype none
module asc_adc_ctrl #(
  parameter int ADDR_W = 8,
  parameter bit EXT_TRIG_EN = 1'b0
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [ADDR_W-1:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  input wire logic [ADDR_W-1:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  input wire asc_pkg::asc_sys_t sys_i,
  input wire logic ext_trig_i,
  input wire logic cmp_i,
  output logic [asc_pkg::RES_W:0] dac_o,
  output logic [4:0] chan_o,
  output logic conv_active_o,
  output logic conv_irq_o,
  output logic irq_o
);
  generate
    if (ADDR_W < 5 || ADDR_W > 32)
    begin : g_chk
      $error("asc_adc_ctrl: ADDR_W must be 5 to 32");
    end
  endgenerate

  asc_pkg::asc_sc_t sc_r;
  asc_pkg::asc_cfg_t cfg_r;
  logic done_r;
  logic run_r;
  logic lock_r;
  logic stop_q_r;
  logic [1:0] trig_sync_r;
  logic trig_q_r;
  logic [asc_pkg::RES_W-1:0] result_r;
  logic [1:0] ist_r;
  logic [1:0] imsk_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic core_busy;
  logic core_done;
  logic [asc_pkg::RES_W-1:0] core_code;
  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire wr_go = s_awvalid_i & s_wvalid_i & ~bvalid_r;
  wire rd_go = s_arvalid_i & ~rvalid_r;
  wire [7:0] wa = 8'(s_awaddr_i);
  wire [7:0] ra = 8'(s_araddr_i);
  wire wr_lane = wr_go & s_wstrb_i[0];
  wire wr_sc = wr_lane & (wa == asc_pkg::SC_OFS);
  wire wr_cfg = wr_lane & (wa == asc_pkg::CFG_OFS);
  wire wr_ist = wr_lane & (wa == asc_pkg::IST_OFS);
  wire wr_imsk = wr_lane & (wa == asc_pkg::IMSK_OFS);
  wire wr_map = (wa == asc_pkg::SC_OFS) | (wa == asc_pkg::RHI_OFS)
              | (wa == asc_pkg::RLO_OFS) | (wa == asc_pkg::CFG_OFS)
              | (wa == asc_pkg::IST_OFS) | (wa == asc_pkg::IMSK_OFS);
  wire rd_rhi = rd_go & (ra == asc_pkg::RHI_OFS);
  wire rd_rlo = rd_go & (ra == asc_pkg::RLO_OFS);
  wire rd_map = (ra == asc_pkg::SC_OFS) | (ra == asc_pkg::RHI_OFS)
              | (ra == asc_pkg::RLO_OFS) | (ra == asc_pkg::CFG_OFS)
              | (ra == asc_pkg::IST_OFS) | (ra == asc_pkg::IMSK_OFS);
  assign s_awready_o = wr_go;
  assign s_wready_o = wr_go;
  assign s_arready_o = rd_go;
  assign s_bvalid_o = bvalid_r;
  assign s_bresp_o = bresp_r;
  assign s_rvalid_o = rvalid_r;
  assign s_rresp_o = rresp_r;
  assign s_rdata_o = rdata_r;
  // ----------------------------------------------------------------
  // Break gating of flag clears
  // ----------------------------------------------------------------
  wire clr_ok = ~sys_i.brk | sys_i.brk_clr_en;
  // ----------------------------------------------------------------
  // Conversion control
  // ----------------------------------------------------------------
  wire [4:0] new_chan = s_wdata_i[4:0];
  wire new_on = (new_chan != asc_pkg::CHAN_OFF);
  wire chan_on = (sc_r.chan != asc_pkg::CHAN_OFF);
  wire stop_enter = sys_i.stop & ~stop_q_r;
  wire kill = stop_enter & ~cfg_r.aclk_en;
  wire trig_ok = EXT_TRIG_EN & trig_sync_r[1];
  wire trig_rise = trig_ok & ~trig_q_r;
  wire blocked = core_done & lock_r;
  wire xfer = core_done & ~lock_r;
  wire wr_start = wr_sc & new_on & ~cfg_r.ext_mode;
  wire ext_start = cfg_r.ext_mode & run_r & chan_on & trig_rise & ~core_busy;
  wire auto_start = core_done & run_r & ~cfg_r.ext_mode & chan_on
                  & (sc_r.cont | blocked);
  wire core_start = (wr_start | ext_start | auto_start) & ~kill;
  wire core_abort = kill | wr_sc;
  wire clr_done = (wr_sc | rd_rlo) & clr_ok;
  wire [1:0] ist_set = {kill, xfer};

  asc_sar_core #(
    .RW(asc_pkg::RES_W),
    .SAMP(asc_pkg::SAMPLE_CYC)
  ) u_core (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .start_i(core_start),
    .abort_i(core_abort),
    .mode10_i(cfg_r.mode10),
    .cmp_i(cmp_i),
    .dac_o(dac_o),
    .busy_o(core_busy),
    .done_o(core_done),
    .code_o(core_code)
  );

  assign chan_o = sc_r.chan;
  assign conv_active_o = core_busy;
  assign conv_irq_o = done_r & sc_r.irq_en;
  assign irq_o = |(ist_r & imsk_r);
  // ----------------------------------------------------------------
  // Control and status registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      sc_r <= asc_pkg::SC_RST[6:0];
      cfg_r <= asc_pkg::CFG_RST;
      imsk_r <= asc_pkg::IRQ_RST;
    end
    else
    begin
      if (wr_sc)
        sc_r <= s_wdata_i[6:0];
      if (wr_cfg)
        cfg_r <= s_wdata_i[2:0];
      if (wr_imsk)
        imsk_r <= s_wdata_i[1:0];
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      stop_q_r <= 1'b0;
      trig_sync_r <= 2'b00;
      trig_q_r <= 1'b0;
    end
    else
    begin
      stop_q_r <= sys_i.stop;
      trig_sync_r <= {trig_sync_r[0], ext_trig_i};
      trig_q_r <= trig_ok;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      run_r <= 1'b0;
    else if (wr_sc)
      run_r <= new_on;
    else if (kill)
      run_r <= 1'b0;
    else if (xfer & ~sc_r.cont & ~cfg_r.ext_mode)
      run_r <= 1'b0;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      lock_r <= 1'b0;
    else if (rd_rlo & clr_ok)
      lock_r <= 1'b0;
    else if (rd_rhi & cfg_r.mode10 & clr_ok)
      lock_r <= 1'b1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      result_r <= asc_pkg::RESULT_RST;
    else if (xfer)
      result_r <= core_code;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      done_r <= 1'b0;
    else if (xfer)
      done_r <= 1'b1;
    else if (clr_done)
      done_r <= 1'b0;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      ist_r <= asc_pkg::IRQ_RST;
    else if (wr_ist & clr_ok)
      ist_r <= (ist_r & ~s_wdata_i[1:0]) | ist_set;
    else
      ist_r <= ist_r | ist_set;
  end
  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [7:0] sc_rd = {done_r, sc_r};
  wire [7:0] rhi_rd = cfg_r.mode10 ? {6'h00, result_r[9:8]} : 8'h00;
  wire [7:0] rlo_rd = result_r[7:0];
  wire [7:0] rd_byte =
    (ra == asc_pkg::SC_OFS) ? sc_rd :
    (ra == asc_pkg::RHI_OFS) ? rhi_rd :
    (ra == asc_pkg::RLO_OFS) ? rlo_rd :
    (ra == asc_pkg::CFG_OFS) ? {5'h00, cfg_r} :
    (ra == asc_pkg::IST_OFS) ? {6'h00, ist_r} :
    (ra == asc_pkg::IMSK_OFS) ? {6'h00, imsk_r} : 8'h00;
  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= asc_pkg::RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_map ? asc_pkg::RESP_OKAY : asc_pkg::RESP_SLVERR;
    end
    else if (s_bready_i)
      bvalid_r <= 1'b0;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      rvalid_r <= 1'b0;
      rresp_r <= asc_pkg::RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end
    else if (rd_go)
    begin
      rvalid_r <= 1'b1;
      rresp_r <= rd_map ? asc_pkg::RESP_OKAY : asc_pkg::RESP_SLVERR;
      rdata_r <= {24'h00_0000, rd_byte};
    end
    else if (s_rready_i)
      rvalid_r <= 1'b0;
  end
endmodule
`default_nettype wire

// ### pkg/asc_pkg.sv
// Constants and carrier types of the converter control block.
// Assumes a single 250 MHz bus clock and an AXI4-Lite register port.
package asc_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SC_OFS = 8'h00;
  localparam logic [7:0] RHI_OFS = 8'h04;
  localparam logic [7:0] RLO_OFS = 8'h08;
  localparam logic [7:0] CFG_OFS = 8'h0c;
  localparam logic [7:0] IST_OFS = 8'h10;
  localparam logic [7:0] IMSK_OFS = 8'h14;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SC_DONE_BIT = 7;
  localparam int SC_IEN_BIT = 6;
  localparam int SC_CONT_BIT = 5;
  localparam int CFG_ACLK_BIT = 0;
  localparam int CFG_M10_BIT = 1;
  localparam int CFG_EXT_BIT = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ABORT_BIT = 1;
  localparam int RES_W = 10;
  localparam logic [4:0] CHAN_OFF = 5'h1f;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SC_RST = 8'h1f;
  localparam logic [2:0] CFG_RST = 3'h0;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam logic [RES_W-1:0] RESULT_RST = 10'h000;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int SAMPLE_NS = 16;
  localparam int SAMPLE_CYC = (SAMPLE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic irq_en;
    logic cont;
    logic [4:0] chan;
  } asc_sc_t;
  typedef struct packed {
    logic ext_mode;
    logic mode10;
    logic aclk_en;
  } asc_cfg_t;
  typedef struct packed {
    logic stop;
    logic brk;
    logic brk_clr_en;
  } asc_sys_t;
endpackage

// ### logic/asc_sar_core.sv
// Successive-approximation sequencer with rounding to 8 or 10 bits.
// Assumes a same-cycle comparator result on cmp_i for the value on dac_o.
`timescale 1ns/10ps
`default_nettype none
module asc_sar_core #(
  parameter int RW = 10,
  parameter int SAMP = 4
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic mode10_i,
  input wire logic cmp_i,
  output logic [RW:0] dac_o,
  output logic busy_o,
  output logic done_o,
  output logic [RW-1:0] code_o
);
  localparam int AW = RW + 1;
  localparam int BW = $clog2(AW);
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_STEP} asc_sar_st_t;

  generate
    if (RW < 3 || SAMP < 1)
    begin : g_chk
      $error("asc_sar_core: unsupported parameters");
    end
  endgenerate

  asc_sar_st_t st_r;
  logic [AW-1:0] dac_r;
  logic [BW-1:0] bit_r;
  logic [7:0] cnt_r;
  logic m10_r;
  logic done_r;
  logic [RW-1:0] code_r;
  // ----------------------------------------------------------------
  // Trial and rounding
  // ----------------------------------------------------------------
  wire [BW-1:0] lo_bit = m10_r ? BW'(0) : BW'(2);
  wire [AW-1:0] cur_oh = AW'(1) << bit_r;
  wire [AW-1:0] nxt_oh = cur_oh >> 1;
  wire [AW-1:0] kept = cmp_i ? dac_r : (dac_r & ~cur_oh);
  wire [AW-1:0] shifted = kept >> lo_bit;
  wire [AW:0] rnd = {1'b0, shifted} + {{AW{1'b0}}, 1'b1};
  wire [RW-1:0] cap = m10_r ? {RW{1'b1}} : RW'(8'hff);
  wire [RW-1:0] rounded = (rnd[AW:1] > {1'b0, cap}) ? cap : rnd[RW:1];
  wire last = (bit_r == lo_bit);

  assign dac_o = dac_r;
  assign busy_o = (st_r != ST_IDLE);
  assign done_o = done_r;
  assign code_o = code_r;
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i)
  begin
    done_r <= 1'b0;
    if (srst_i)
    begin
      st_r <= ST_IDLE;
      dac_r <= '0;
      bit_r <= '0;
      cnt_r <= '0;
      m10_r <= 1'b0;
      code_r <= '0;
    end
    else if (start_i)
    begin
      st_r <= ST_SAMPLE;
      cnt_r <= 8'(SAMP - 1);
      m10_r <= mode10_i;
      dac_r <= '0;
    end
    else if (abort_i)
      st_r <= ST_IDLE;
    else
    begin
      unique case (st_r)
        ST_IDLE: st_r <= ST_IDLE;
        ST_SAMPLE:
        begin
          cnt_r <= cnt_r - 8'd1;
          if (cnt_r == 8'd0)
          begin
            st_r <= ST_STEP;
            bit_r <= BW'(AW - 1);
            dac_r <= AW'(1) << (AW - 1);
          end
        end
        ST_STEP:
        begin
          if (last)
          begin
            st_r <= ST_IDLE;
            code_r <= rounded;
            done_r <= 1'b1;
            dac_r <= kept;
          end
          else
          begin
            bit_r <= bit_r - BW'(1);
            dac_r <= kept | nxt_oh;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### dv/asc_ana_src.sv
// Analog source model: one held input level and its comparator.
// Assumes the trial value and the level share one 11-bit scale.
`timescale 1ns/10ps
`default_nettype none
module asc_ana_src (
  input wire logic [asc_pkg::RES_W:0] lvl_i,
  input wire logic [asc_pkg::RES_W:0] dac_i,
  output logic cmp_o
);
  // ----
  // Comparator
  // ----
  assign cmp_o = (lvl_i >= dac_i);
endmodule
`default_nettype wire

// ### dv/asc_adc_ctrl_asserts.sv
// Concurrent checks on the ports of the converter control block.
// Assumes one clock and the byte offsets of the package.
`timescale 1ns/10ps
`default_nettype none
module asc_adc_ctrl_asserts #(
  parameter int ADDR_W = 8
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [ADDR_W-1:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  input wire logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  input wire logic s_bvalid_o,
  input wire logic [ADDR_W-1:0] s_araddr_i,
  input wire logic s_arvalid_i,
  input wire logic s_arready_o,
  input wire logic [31:0] s_rdata_o,
  input wire logic s_rvalid_o,
  input wire logic s_rready_i,
  input wire asc_pkg::asc_sys_t sys_i,
  input wire logic [4:0] chan_o,
  input wire logic conv_active_o,
  input wire logic conv_irq_o
);
  // ----
  // Helper state
  // ----
  logic aclk_r;
  logic stop_r;
  logic park_r;
  wire wr_tk = s_awvalid_i & s_awready_o & s_wvalid_i & s_wstrb_i[0];
  wire rd_tk = s_arvalid_i & s_arready_o;
  wire sc_wr = wr_tk & (s_awaddr_i == ADDR_W'(asc_pkg::SC_OFS));
  wire cfg_wr = wr_tk & (s_awaddr_i == ADDR_W'(asc_pkg::CFG_OFS));
  wire prot = sys_i.brk & ~sys_i.brk_clr_en;
  wire stop_up = sys_i.stop & ~stop_r & ~aclk_r;
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      aclk_r <= 1'b0;
      stop_r <= 1'b0;
      park_r <= 1'b0;
    end
    else
    begin
      stop_r <= sys_i.stop;
      if (cfg_wr)
        aclk_r <= s_wdata_i[asc_pkg::CFG_ACLK_BIT];
      if (stop_up)
        park_r <= 1'b1;
      else if (sc_wr)
        park_r <= 1'b0;
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  sequence rlo_rd_s;
    rd_tk && s_araddr_i == ADDR_W'(asc_pkg::RLO_OFS);
  endsequence
  sequence irq_held_s;
    conv_irq_o [*2];
  endsequence
  wr_resp_a: assert property (wr_tk |=> s_bvalid_o)
    else $error("write not answered");
  rd_resp_a: assert property (rd_tk |=> s_rvalid_o)
    else $error("read not answered");
  rd_hold_a: assert property (s_rvalid_o && !s_rready_i |=> s_rvalid_o && $stable(s_rdata_o))
    else $error("read answer not held");
  rd_upper_a: assert property (s_rvalid_o |-> s_rdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  stop_abort_a: assert property (stop_up |-> ##[1:3] !conv_active_o)
    else $error("stop did not abort");
  stop_park_a: assert property (park_r && $past(park_r, 3) |-> !conv_active_o)
    else $error("converter left idle before control write");
  ctl_clear_a: assert property (sc_wr && !prot |-> ##[1:2] !conv_irq_o)
    else $error("control write left request up");
  brk_keep_a: assert property (rlo_rd_s ##0 (prot && conv_irq_o) |=> irq_held_s)
    else $error("protected read changed flag");
  chan_off_a: assert property ((chan_o == asc_pkg::CHAN_OFF) [*3] |-> !conv_active_o)
    else $error("converter busy with channel off");
endmodule
`default_nettype wire

// ### dv/asc_adc_ctrl_tb.sv
// Self-checking bench of the converter control block over its register port.
// Assumes the analog source model on the comparator; sys_i driven here.
`timescale 1ns/10ps
`default_nettype none
module asc_adc_ctrl_tb;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] aw = 8'h0;
  logic [7:0] ar = 8'h0;
  logic [31:0] wd = 32'h0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bry = 1'b0;
  logic arv = 1'b0;
  logic rry = 1'b0;
  logic trig = 1'b0;
  asc_pkg::asc_sys_t sys = 3'h0;
  logic [10:0] vin = 11'h0;
  logic [10:0] dac;
  logic [31:0] rdt;
  logic [1:0] rr;
  logic [1:0] rsp;
  logic awr, wrd, bv, arr, rv, cmp, act, cirq, irq;
  logic [1:0] br;
  logic [1:0] wrsp;
  logic [4:0] chn;
  int err_count = 0;
  int n_compared = 0;
  int last_code = 0;
  int exp_q[$];
  initial
  begin
    forever #2 mclk_i = ~mclk_i;
  end
  asc_adc_ctrl asc_adc_ctrl_i (
    .mclk_i(mclk_i), .srst_i(srst_i), .s_awaddr_i(aw), .s_awvalid_i(awv),
    .s_awready_o(awr), .s_wdata_i(wd), .s_wstrb_i(4'h1), .s_wvalid_i(wv),
    .s_wready_o(wrd), .s_bresp_o(br), .s_bvalid_o(bv), .s_bready_i(bry),
    .s_araddr_i(ar), .s_arvalid_i(arv), .s_arready_o(arr), .s_rdata_o(rdt),
    .s_rresp_o(rr), .s_rvalid_o(rv), .s_rready_i(rry), .sys_i(sys),
    .ext_trig_i(trig), .cmp_i(cmp), .dac_o(dac), .chan_o(chn), .conv_active_o(act),
    .conv_irq_o(cirq), .irq_o(irq)
  );
  asc_ana_src asc_ana_src_i (.lvl_i(vin), .dac_i(dac), .cmp_o(cmp));
  // ----
  // Tasks
  // ----
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic sg(input int k);
    case (k)
      0: return awr & wrd;
      1: return bv;
      2: return arr;
      3: return rv;
      4: return irq;
      default: return act;
    endcase
  endfunction
  task automatic wt(input int k);
    int n;
    n = 0;
    do
    begin
      @(negedge mclk_i);
      n++;
      if (n > 500)
      begin
        err_count++;
        results();
      end
    end
    while (sg(k) !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    wt(0);
    @(posedge mclk_i);
    awv <= 1'b0;
    wv <= 1'b0;
    bry <= 1'b1;
    wt(1);
    @(posedge mclk_i);
    wrsp = br;
    bry <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ar <= a;
    arv <= 1'b1;
    wt(2);
    @(posedge mclk_i);
    arv <= 1'b0;
    rry <= 1'b1;
    wt(3);
    @(posedge mclk_i);
    d = rdt;
    rsp = rr;
    rry <= 1'b0;
  endtask
  task automatic conv(input int m10, input int ien);
    logic [31:0] d;
    int v;
    v = $urandom_range(255) * 8;
    exp_q.push_back(m10 ? v / 2 : v / 8);
    vin <= 11'(v);
    wr(asc_pkg::CFG_OFS, 32'(m10 * 2));
    wr(asc_pkg::SC_OFS, 32'(128 + ien * 64));
    wt(4);
    @(posedge mclk_i);
    chk("irq req", 32'(cirq), 32'(ien));
    rd(asc_pkg::SC_OFS, d);
    chk("done", d, 32'(128 + ien * 64));
    last_code = exp_q.pop_front();
    rd(asc_pkg::RHI_OFS, d);
    chk("rhi", d, 32'(last_code / 256));
    rd(asc_pkg::RLO_OFS, d);
    chk("rlo", d, 32'(last_code % 256));
    chk("irq clr", 32'(cirq), 32'h0);
    chk("idle", 32'(act), 32'h0);
    wr(asc_pkg::IST_OFS, 32'h3);
    chk("irq line", 32'(irq), 32'h0);
  endtask
  // ----
  // Main sequence
  // ----
  initial
  begin
    logic [31:0] d;
    int i;
    void'($urandom(32'h0000_b70a));
    repeat (5) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(posedge mclk_i);
    for (i = 0; i < 7; i++)
    begin
      rd(8'(i * 4), d);
      chk("rst", d, (i == 0) ? 32'(asc_pkg::SC_RST) : 32'h0);
      chk("resp", 32'(rsp), (i == 6) ? 32'(asc_pkg::RESP_SLVERR) : 32'h0);
    end
    wr(asc_pkg::SC_OFS, 32'h9f);
    rd(asc_pkg::SC_OFS, d);
    chk("sc ro", d, 32'h1f);
    chk("off", 32'(act), 32'h0);
    chk("wresp", 32'(wrsp), 32'h0);
    chk("chan", 32'(chn), 32'h1f);
    wr(8'h18, 32'h0000_00ff);
    chk("wresp bad", 32'(wrsp), 32'(asc_pkg::RESP_SLVERR));
    $display("test reset done");
    wr(asc_pkg::IMSK_OFS, 32'h3);
    for (i = 0; i < 8; i++)
      conv(i % 2, (i / 2) % 2);
    $display("test single done");
    vin <= ~vin & 11'h7f8;
    wr(asc_pkg::SC_OFS, 32'h20);
    wt(5);
    @(posedge mclk_i);
    sys.stop <= 1'b1;
    repeat (4) @(posedge mclk_i);
    chk("abort", 32'(act), 32'h0);
    sys.stop <= 1'b0;
    repeat (40) @(posedge mclk_i);
    chk("parked", 32'(act), 32'h0);
    rd(asc_pkg::RLO_OFS, d);
    chk("kept", d, 32'(last_code % 256));
    rd(asc_pkg::IST_OFS, d);
    chk("abort st", d, 32'h2);
    wr(asc_pkg::IST_OFS, 32'h3);
    conv(1, 1);
    $display("test stop done");
    wr(asc_pkg::CFG_OFS, 32'h3);
    wr(asc_pkg::SC_OFS, 32'h60);
    sys.stop <= 1'b1;
    wt(4);
    @(posedge mclk_i);
    chk("stop irq", 32'(cirq), 32'h1);
    wr(asc_pkg::IST_OFS, 32'h3);
    wt(4);
    @(posedge mclk_i);
    wr(asc_pkg::SC_OFS, 32'h1f);
    sys.stop <= 1'b0;
    rd(asc_pkg::RLO_OFS, d);
    chk("cont", d, 32'(last_code % 256));
    repeat (30) @(posedge mclk_i);
    chk("off", 32'(act), 32'h0);
    $display("test async done");
    wr(asc_pkg::IST_OFS, 32'h3);
    wr(asc_pkg::SC_OFS, 32'h40);
    wt(4);
    @(posedge mclk_i);
    rd(asc_pkg::RHI_OFS, d);
    sys <= 3'b010;
    rd(asc_pkg::RLO_OFS, d);
    chk("brk keep", 32'(cirq), 32'h1);
    wr(asc_pkg::IST_OFS, 32'h3);
    chk("brk st", 32'(irq), 32'h1);
    sys <= 3'b000;
    rd(asc_pkg::RLO_OFS, d);
    chk("step two", 32'(cirq), 32'h0);
    wr(asc_pkg::IST_OFS, 32'h3);
    wr(asc_pkg::SC_OFS, 32'h40);
    wt(4);
    @(posedge mclk_i);
    sys <= 3'b011;
    rd(asc_pkg::RLO_OFS, d);
    sys <= 3'b000;
    repeat (2) @(posedge mclk_i);
    chk("brk clr", 32'(cirq), 32'h0);
    $display("test break done");
    wr(asc_pkg::CFG_OFS, 32'h5);
    wr(asc_pkg::SC_OFS, 32'h0);
    sys.stop <= 1'b1;
    trig <= 1'b1;
    repeat (20) @(posedge mclk_i);
    chk("no trig", 32'(act), 32'h0);
    chk("irq set", 32'(irq), 32'h1);
    wr(asc_pkg::IMSK_OFS, 32'h0);
    chk("irq mask", 32'(irq), 32'h0);
    $display("test trigger done");
    results();
  end
endmodule
bind asc_adc_ctrl asc_adc_ctrl_asserts #(.ADDR_W(ADDR_W)) asrt_i (
  .mclk_i(mclk_i), .srst_i(srst_i), .s_awaddr_i(s_awaddr_i), .s_awvalid_i(s_awvalid_i),
  .s_awready_o(s_awready_o), .s_wdata_i(s_wdata_i), .s_wstrb_i(s_wstrb_i),
  .s_wvalid_i(s_wvalid_i), .s_bvalid_o(s_bvalid_o), .s_araddr_i(s_araddr_i),
  .s_arvalid_i(s_arvalid_i), .s_arready_o(s_arready_o), .s_rdata_o(s_rdata_o),
  .s_rvalid_o(s_rvalid_o), .s_rready_i(s_rready_i), .sys_i(sys_i), .chan_o(chan_o),
  .conv_active_o(conv_active_o), .conv_irq_o(conv_irq_o)
);
`default_nettype wire
